//--- hdl/button_reset_pkg.sv
// Package for the dual push-button reset timer.
// Assumes a 200 MHz clock; counts are derived from times here.
package button_reset_pkg;

	// ****************************************
	// Clock and times
	// ****************************************
	localparam int unsigned CLK_FREQ_HZ = 200_000_000;
	localparam int unsigned HOLD_TIME_OPEN_S = 2;
	localparam int unsigned HOLD_TIME_GND_S = 4;
	localparam int unsigned HOLD_TIME_SUPPLY_S = 6;
	localparam int unsigned PULSE_WIDTH_X_MS = 140;
	localparam int unsigned PULSE_WIDTH_Y_MS = 240;

	// ****************************************
	// Derived cycle counts
	// ****************************************
	localparam longint unsigned HOLD_CYCLES_OPEN = longint'(HOLD_TIME_OPEN_S) * CLK_FREQ_HZ;
	localparam longint unsigned HOLD_CYCLES_GND = longint'(HOLD_TIME_GND_S) * CLK_FREQ_HZ;
	localparam longint unsigned HOLD_CYCLES_SUPPLY = longint'(HOLD_TIME_SUPPLY_S) * CLK_FREQ_HZ;
	localparam longint unsigned PULSE_CYCLES_X = (longint'(PULSE_WIDTH_X_MS) * CLK_FREQ_HZ + 999) / 1000;
	localparam longint unsigned PULSE_CYCLES_Y = (longint'(PULSE_WIDTH_Y_MS) * CLK_FREQ_HZ + 999) / 1000;
	localparam int COUNT_W = 31;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		HOLD_SEL_OPEN,
		HOLD_SEL_GND,
		HOLD_SEL_SUPPLY,
		HOLD_SEL_SPARE
	} hold_sel_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_HOLDING,
		ST_PULSE,
		ST_WAIT_RELEASE
	} timer_state_t;

endpackage : button_reset_pkg

//--- hdl/dual_button_reset_timer.sv
// Dual push-button reset timer: two held buttons give one fixed reset pulse.
// Assumes inputs already synchronous to clk and a supply-good level input.
//
// What this block does
// - Hold time is 2 s open, 4 s ground, 6 s supply on the selector.
// - Output behaviour is the same whichever request input falls first.
// - Both outputs assert once hold time elapses with both requests low.
// - One reset pulse of configured width follows a completed hold.
// - Holding both requests low after the pulse gives no further pulse.
// - Pulse width is fixed at build, at least 140 ms or 240 ms.
// - Open-drain output pulls low, push-pull high, always mutual inverses.
// - Outputs stay deasserted while supply is below 1.6 V.
`timescale 1ns/10ps

module dual_button_reset_timer
	import button_reset_pkg::*;
#(
	parameter longint unsigned HOLD_OPEN = HOLD_CYCLES_OPEN,
	parameter longint unsigned HOLD_GND = HOLD_CYCLES_GND,
	parameter longint unsigned HOLD_SUPPLY = HOLD_CYCLES_SUPPLY,
	parameter bit PULSE_OPTION_Y = 1'h0,
	parameter longint unsigned PULSE_X = PULSE_CYCLES_X,
	parameter longint unsigned PULSE_Y = PULSE_CYCLES_Y
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Supply monitor
	input wire logic supply_ok,
	// Button requests
	input wire logic manual_request_a_n,
	input wire logic manual_request_b_n,
	// Three-state selector, decoded outside
	input wire button_reset_pkg::hold_sel_t hold_time_select,
	// Reset outputs
	output logic reset_out_low_active_o,
	output logic reset_out_low_active_oe,
	output logic reset_out_high_active
);
	import button_reset_pkg::*;

	// ****************************************
	// Cycle walk
	// ****************************************
	// Edge c0 sees both requests low: hold count starts at one
	// Edge cH, with the count at the hold limit, moves to the pulse
	// Outputs follow the state one edge later and stand PULSE_LIMIT cycles
	// A press still held after the pulse parks in the wait state
	// Either request going high mid-hold drops back to idle, no pulse
	// Low supply or reset clears state, counter and outputs on one edge

	// ****************************************
	// Length lookups
	// ****************************************
	// Unused selector code behaves as the open setting
	function automatic logic [COUNT_W-1:0] hold_limit(input hold_sel_t sel);
		case (sel)
			HOLD_SEL_GND: hold_limit = COUNT_W'(HOLD_GND);
			HOLD_SEL_SUPPLY: hold_limit = COUNT_W'(HOLD_SUPPLY);
			default: hold_limit = COUNT_W'(HOLD_OPEN);
		endcase
	endfunction : hold_limit

	function automatic logic [COUNT_W-1:0] pulse_limit(input bit option_y);
		if (option_y) begin
			pulse_limit = COUNT_W'(PULSE_Y);
		end else begin
			pulse_limit = COUNT_W'(PULSE_X);
		end
	endfunction : pulse_limit

	// ****************************************
	// Counter arithmetic
	// ****************************************
	// Saturates rather than wraps; a wrapped count would stretch a phase
	function automatic logic [COUNT_W-1:0] count_step(input logic [COUNT_W-1:0] value);
		if (value == '1) begin
			count_step = value;
		end else begin
			count_step = value + COUNT_W'(1);
		end
	endfunction : count_step

	function automatic logic limit_reached(input logic [COUNT_W-1:0] value, input logic [COUNT_W-1:0] limit);
		limit_reached = (value >= limit);
	endfunction : limit_reached

	// ****************************************
	// Internal signals
	// ****************************************
	localparam logic [COUNT_W-1:0] PULSE_LIMIT = pulse_limit(PULSE_OPTION_Y);

	timer_state_t state_reg;
	logic [COUNT_W-1:0] count_reg;
	logic [COUNT_W-1:0] hold_target;
	logic quiet;
	logic both_low;
	logic hold_abort;
	logic hold_done;
	logic pulse_done;
	logic pulse_active;

	// ****************************************
	// Request decode
	// ****************************************
	// Low supply acts exactly like reset, so nothing half-finished survives it
	assign quiet = rst || !supply_ok;

	// Symmetric AND, so press order cannot matter
	assign both_low = !manual_request_a_n && !manual_request_b_n;

	// ****************************************
	// Phase events
	// ****************************************
	assign hold_target = hold_limit(hold_time_select);
	assign hold_abort = (state_reg == ST_HOLDING) && !both_low;
	assign hold_done = (state_reg == ST_HOLDING) && both_low && limit_reached(count_reg, hold_target);
	assign pulse_done = (state_reg == ST_PULSE) && limit_reached(count_reg, PULSE_LIMIT);
	assign pulse_active = (state_reg == ST_PULSE);

	// ****************************************
	// Sequencer state
	// ****************************************
	always_ff @(posedge clk) begin
		if (quiet) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (both_low) begin
						state_reg <= ST_HOLDING;
					end
				end
				ST_HOLDING: begin
					if (hold_abort) begin
						state_reg <= ST_IDLE;
					end else if (hold_done) begin
						state_reg <= ST_PULSE;
					end
				end
				ST_PULSE: begin
					if (pulse_done) begin
						state_reg <= ST_WAIT_RELEASE;
					end
				end
				default: begin
					// Re-arm only after a release, so a long press yields one pulse
					if (!both_low) begin
						state_reg <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// ****************************************
	// Hold and pulse counter
	// ****************************************
	// One counter serves both phases; it restarts at one on each phase entry
	always_ff @(posedge clk) begin
		if (quiet) begin
			count_reg <= '0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (both_low) begin
						count_reg <= COUNT_W'(1);
					end else begin
						count_reg <= '0;
					end
				end
				ST_HOLDING: begin
					if (hold_abort) begin
						count_reg <= '0;
					end else if (hold_done) begin
						count_reg <= COUNT_W'(1);
					end else begin
						count_reg <= count_step(count_reg);
					end
				end
				ST_PULSE: begin
					if (pulse_done) begin
						count_reg <= '0;
					end else begin
						count_reg <= count_step(count_reg);
					end
				end
				default: begin
					count_reg <= '0;
				end
			endcase
		end
	end

	// ****************************************
	// Open-drain reset pin
	// ****************************************
	// Pin only ever drives low; data held at zero
	always_ff @(posedge clk) begin
		reset_out_low_active_o <= 1'h0;
	end

	// Enable high while the pin is pulled low
	always_ff @(posedge clk) begin
		if (quiet) begin
			reset_out_low_active_oe <= 1'h0;
		end else begin
			reset_out_low_active_oe <= pulse_active;
		end
	end

	// ****************************************
	// Push-pull reset pin
	// ****************************************
	// Same source as the enable, so the two pins stay exact inverses
	always_ff @(posedge clk) begin
		if (quiet) begin
			reset_out_high_active <= 1'h0;
		end else begin
			reset_out_high_active <= pulse_active;
		end
	end

endmodule : dual_button_reset_timer

//--- testbench/button_pair.sv
// Two push buttons on pulled-up request lines.
// Assumes press changes just after a clock edge.
`timescale 1ns/10ps
module button_pair (input wire logic clk, input wire logic [1:0] press,
	output logic manual_request_a_n = 1'h1, output logic manual_request_b_n = 1'h1);
	// Released lines float high through the pull-ups
	always @(posedge clk) {manual_request_b_n, manual_request_a_n} <= ~press;
endmodule : button_pair

//--- testbench/reset_timer_monitor.sv
// Checker on the reset timer ports.
// Assumes the pulse length of the build it is bound into.
`timescale 1ns/10ps
module reset_timer_monitor #(
	parameter longint unsigned HOLD_OPEN = 1,
	parameter longint unsigned HOLD_GND = 1,
	parameter longint unsigned HOLD_SUPPLY = 1,
	parameter longint unsigned PULSE_X = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Supply and requests
	input wire logic supply_ok,
	input wire logic manual_request_a_n,
	input wire logic manual_request_b_n,
	input wire logic [1:0] hold_time_select,
	// Reset outputs
	input wire logic reset_out_low_active_o,
	input wire logic reset_out_low_active_oe,
	input wire logic reset_out_high_active
);
	wire hi = reset_out_high_active;
	wire lo = !manual_request_a_n && !manual_request_b_n;
	// Hold the current selector asks for; code 3 counts as open
	wire [63:0] need = hold_time_select == 2'h1 ? HOLD_GND : hold_time_select == 2'h2 ? HOLD_SUPPLY : HOLD_OPEN;
	logic [63:0] nl, nh;
	logic rearm;
	always_ff @(posedge clk) nl <= lo ? nl + 64'h1 : 64'h0;
	always_ff @(posedge clk) nh <= hi ? nh + 64'h1 : 64'h0;
	// Set by a release, reset or supply loss; cleared while a pulse stands
	always_ff @(posedge clk) rearm <= !lo || rst || !supply_ok ? 1'h1 : hi ? 1'h0 : rearm;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	chk_hold_met: assert property ($rose(hi) |-> $past(nl, 2) >= $past(need, 2))
		else $error("early");
	chk_one_pulse: assert property ($rose(hi) |-> $past(rearm)) else $error("repeat");
	chk_pulse_len: assert property ($fell(hi) && $past(supply_ok && !rst) |-> nh == PULSE_X)
		else $error("width");
	chk_out_pair: assert property (hi == reset_out_low_active_oe) else $error("pair");
	chk_drain_low: assert property (!reset_out_low_active_o) else $error("drain");
	chk_supply_off: assert property (!supply_ok |=> !hi) else $error("supply");
	chk_held_quiet: assert property ($fell(hi) && lo |=> !hi [*8]) else $error("again");
	chk_both_low: assert property ($rose(hi) |-> $past(lo, 2)) else $error("both");
	chk_reset_idle: assert property ($fell(rst) |-> !hi) else $error("reset");
endmodule : reset_timer_monitor
bind dual_button_reset_timer reset_timer_monitor #(
	.HOLD_OPEN(HOLD_OPEN),
	.HOLD_GND(HOLD_GND),
	.HOLD_SUPPLY(HOLD_SUPPLY),
	.PULSE_X(PULSE_OPTION_Y ? PULSE_Y : PULSE_X)
) u_mon (
	.clk(clk),
	.rst(rst),
	.supply_ok(supply_ok),
	.manual_request_a_n(manual_request_a_n),
	.manual_request_b_n(manual_request_b_n),
	.hold_time_select(hold_time_select),
	.reset_out_low_active_o(reset_out_low_active_o),
	.reset_out_low_active_oe(reset_out_low_active_oe),
	.reset_out_high_active(reset_out_high_active)
);

//--- testbench/tb_top.sv
// Random button presses on the reset timer.
// Assumes hold counts 20/40/60 and pulse 10.
`timescale 1ns/10ps
module tb_top;
	import button_reset_pkg::*;
	logic clk = 1'h0, rst = 1'h1, supply_ok = 1'h1, pv = 1'h0;
	logic manual_request_a_n, manual_request_b_n, reset_out_high_active;
	logic reset_out_low_active_o, reset_out_low_active_oe;
	logic [1:0] press = 2'h0;
	hold_sel_t hold_time_select = HOLD_SEL_OPEN;
	int miscompares = 0, checked = 0, np = 0, nh = 0, nd = 0, h, k;
	function automatic int hold_of(int i);
		return (i % 4 == 3 ? 1 : i % 4 + 1) * 20;
	endfunction : hold_of
	task automatic check(string n, int e, int g);
		checked++;
		if (e != g) begin
			miscompares++;
			$display("ERROR %s expected %0d seen %0d", n, e, g);
		end
	endtask : check
	task automatic conclude();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : conclude
	button_pair u_btn (.clk(clk), .press(press), .manual_request_a_n(manual_request_a_n),
		.manual_request_b_n(manual_request_b_n));
	dual_button_reset_timer #(.HOLD_OPEN(20), .HOLD_GND(40), .HOLD_SUPPLY(60), .PULSE_X(10)) u_dut (.clk(clk),
		.rst(rst), .supply_ok(supply_ok), .manual_request_a_n(manual_request_a_n),
		.manual_request_b_n(manual_request_b_n), .hold_time_select(hold_time_select),
		.reset_out_low_active_o(reset_out_low_active_o), .reset_out_low_active_oe(reset_out_low_active_oe),
		.reset_out_high_active(reset_out_high_active));
	initial forever #2.5 clk = ~clk;
	// Sampled mid-cycle, away from the edge that launches the outputs
	always @(negedge clk) begin
		np += reset_out_high_active === 1'h1 && pv !== 1'h1;
		nh += reset_out_high_active === 1'h1;
		// Pin level with its pull-up: a released drain reads high
		nd += (reset_out_low_active_oe === 1'h1 ? reset_out_low_active_o : 1'h1) === 1'h0;
		pv = reset_out_high_active;
	end
	initial begin
		void'($urandom(90));
		repeat (20) @(posedge clk);
		rst <= 1'h0;
		for (int i = 0; i < 12; i++) begin
			k = i / 4;
			h = hold_of(i);
			@(negedge clk) np = 0;
			nh = 0;
			nd = 0;
			@(posedge clk) hold_time_select <= hold_sel_t'(i % 4);
			supply_ok <= k != 2;
			press <= 2'($urandom_range(1, 2));
			repeat ($urandom_range(1, 4)) @(posedge clk);
			press <= 2'h3;
			// Short press falls 5 cycles short of the current setting; long one spans a second hold
			repeat (k == 1 ? h - 5 : 2 * h + 20) @(posedge clk);
			press <= 2'h0;
			repeat (10) @(posedge clk);
			check("pulses", k == 0, np);
			check("high cycles", k == 0 ? 10 : 0, nh);
			check("drain low cycles", k == 0 ? 10 : 0, nd);
		end
		conclude();
	end
endmodule : tb_top
